// ### verilog/pwm_phase_dt.sv
// PWM generator secondary phase and dead-time registers with low/high time bases
//
// Contract
// - 16-bit secondary phase register, reset zero
// - Secondary phase ignored outside independent mode
// - Independent, base off: low-side phase shift
// - Independent, base on: low-side separate period
// - 14-bit dead-time register, writable, reset zero
// - 14-bit alternate dead-time register, reset zero
// - Dead-time upper 18 bits (31:14) read zero
// - Independent, base off: primary phase high-side
//
// The APB slave port and the address map were left to the implementer.
`include "pwm_phase_dt_defs.svh"
module pwm_phase_dt #(
  parameter int PHASE_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Time base and dead-time outputs
  output logic [PHASE_W-1:0] high_count,
  output logic [PHASE_W-1:0] low_count,
  output logic low_uses_secondary,
  output logic [`DT_WIDTH-1:0] dead_time,
  output logic [`DT_WIDTH-1:0] alt_dead_time
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (PHASE_W != 16) begin : g_bad_phase_w
    $error("PHASE_W must be 16");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic sel_ctrl;
  logic sel_pphase;
  logic sel_sphase;
  logic sel_dt;
  logic sel_alt_dt;
  logic sel_status;
  logic hit;
  logic setup_ph;
  logic wr_en;
  logic rd_en;

  assign sel_ctrl = (paddr == `OFF_CTRL);
  assign sel_pphase = (paddr == `OFF_PRIMARY_PHASE);
  assign sel_sphase = (paddr == `OFF_SECONDARY_PHASE);
  assign sel_dt = (paddr == `OFF_DEAD_TIME);
  assign sel_alt_dt = (paddr == `OFF_ALT_DEAD_TIME);
  assign sel_status = (paddr == `OFF_STATUS);
  assign hit = sel_ctrl || sel_pphase || sel_sphase || sel_dt || sel_alt_dt || sel_status;
  assign setup_ph = psel && !penable;
  // Writes land at the access edge only
  assign wr_en = psel && penable && pwrite && pready;
  // Read data is taken in setup so it stands through the access cycle
  assign rd_en = setup_ph && !pwrite;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic tb_sel_r;
  logic en_r;
  pwm_phase_dt_pkg::output_mode_t mode_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_sel_r <= 1'b0;
      en_r <= 1'b0;
      mode_r <= pwm_phase_dt_pkg::MODE_COMPLEMENTARY;
    end else if (wr_en && sel_ctrl) begin
      tb_sel_r <= pwdata[`CTRL_TB_SEL_BIT];
      mode_r <= pwm_phase_dt_pkg::output_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
      en_r <= pwdata[`CTRL_EN_BIT];
    end
  end

  // ----------------------------------------
  // Phase registers
  // ----------------------------------------
  logic [15:0] primary_phase_r;
  logic [15:0] secondary_phase_r;

  // Primary phase or high-side period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_phase_r <= `RST_PHASE;
    end else if (wr_en && sel_pphase) begin
      primary_phase_r <= pwdata[15:0];
    end
  end

  // Secondary phase or low-side period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_phase_r <= `RST_PHASE;
    end else if (wr_en && sel_sphase) begin
      secondary_phase_r <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Dead-time registers
  // ----------------------------------------
  logic [`DT_WIDTH-1:0] dt_r;
  logic [`DT_WIDTH-1:0] alt_dt_r;

  // Upper write bits are dropped, so they cannot be stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_r <= `RST_DT;
    end else if (wr_en && sel_dt) begin
      dt_r <= pwdata[`DT_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_dt_r <= `RST_DT;
    end else if (wr_en && sel_alt_dt) begin
      alt_dt_r <= pwdata[`DT_WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // One access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit;
    end
  end

  // Read data stands until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      if (rd_en) begin
        case (paddr)
          `OFF_CTRL: prdata <= {28'h0000000, en_r, mode_r, tb_sel_r};
          `OFF_PRIMARY_PHASE: prdata <= {16'h0000, primary_phase_r};
          `OFF_SECONDARY_PHASE: prdata <= {16'h0000, secondary_phase_r};
          `OFF_DEAD_TIME: prdata <= {18'h00000, dt_r};
          `OFF_ALT_DEAD_TIME: prdata <= {18'h00000, alt_dt_r};
          `OFF_STATUS: prdata <= {low_count, high_count};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Time bases
  // ----------------------------------------
  logic indep;
  logic [15:0] high_per;
  assign indep = (mode_r == pwm_phase_dt_pkg::MODE_INDEPENDENT);
  assign high_per = tb_sel_r ? primary_phase_r : 16'hFFFF;

  // High side: primary phase shift or independent period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_count <= 16'h0000;
    end else if (!en_r) begin
      high_count <= tb_sel_r ? 16'h0000 : primary_phase_r;
    end else if (high_count >= high_per) begin
      high_count <= 16'h0000;
    end else begin
      high_count <= high_count + 16'h0001;
    end
  end

  // Low side: follows high side unless independent mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_count <= 16'h0000;
      low_uses_secondary <= 1'b0;
    end else begin
      low_uses_secondary <= indep;
      if (!indep) begin
        low_count <= high_count;
      end else if (!en_r) begin
        low_count <= tb_sel_r ? 16'h0000 : secondary_phase_r;
      end else if (tb_sel_r && low_count >= secondary_phase_r) begin
        low_count <= 16'h0000;
      end else if (!tb_sel_r && low_count == 16'hFFFF) begin
        low_count <= 16'h0000;
      end else begin
        low_count <= low_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Dead-time outputs
  // ----------------------------------------
  // Dead-time values to the dead-time unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_time <= `RST_DT;
      alt_dead_time <= `RST_DT;
    end else begin
      dead_time <= dt_r;
      alt_dead_time <= alt_dt_r;
    end
  end
endmodule // pwm_phase_dt

// ### verilog/pwm_phase_dt_defs.svh
// Register offsets, field positions and reset values of the phase and dead-time block
`ifndef PWM_PHASE_DT_DEFS_SVH
`define PWM_PHASE_DT_DEFS_SVH
`define OFF_CTRL 12'h000
`define OFF_PRIMARY_PHASE 12'h004
`define OFF_SECONDARY_PHASE 12'h008
`define OFF_DEAD_TIME 12'h00C
`define OFF_ALT_DEAD_TIME 12'h010
`define OFF_STATUS 12'h014
`define CTRL_TB_SEL_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_EN_BIT 3
`define RST_PHASE 16'h0000
`define RST_DT 14'h0000
`define DT_WIDTH 14
`endif

// ### verilog/pwm_phase_dt_pkg.sv
// Types of the phase and dead-time block
package pwm_phase_dt_pkg;
  typedef enum logic [1:0] {
    MODE_COMPLEMENTARY = 2'h0,
    MODE_REDUNDANT = 2'h1,
    MODE_PUSH_PULL = 2'h2,
    MODE_INDEPENDENT = 2'h3
  } output_mode_t;
endpackage

// ### dv/pwm_phase_dt_monitor.sv
// Checker of the phase and dead-time block
module pwm_phase_dt_monitor #(parameter int PHASE_W = 16) (
  input logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_uses_secondary,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [PHASE_W-1:0] high_count, low_count,
  input logic [13:0] dead_time, alt_dead_time
);
  wire acc = psel && penable && pready;
  wire wdt = acc && pwrite && paddr == 12'h00C;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rdy_once: assert property (psel && !penable |=> pready ##1 !pready) else $error("rdy");
  a_low_copy: assert property (!low_uses_secondary [*2] |-> low_count == $past(high_count))
    else $error("low");
  a_dt_set: assert property (wdt |=> ##1 dead_time == $past(pwdata[13:0], 2))
    else $error("dt");
  a_alt_set: assert property (acc && pwrite && paddr == 12'h010 |=> ##1
    alt_dead_time == $past(pwdata[13:0], 2)) else $error("alt");
  a_dt_hold: assert property (!$past(wdt, 2) |-> $stable(dead_time)) else $error("hold");
  a_dt_top: assert property (acc && !pwrite && paddr inside {12'h00C, 12'h010}
    |-> !prdata[31:14]) else $error("top");
  a_sec_top: assert property (acc && !pwrite && paddr == 12'h008 |-> !prdata[31:16])
    else $error("sec");
  a_bad_addr: assert property (acc |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014}))
    else $error("addr");
  cover property (wdt);
  cover property (low_uses_secondary);
  cover property (acc && pslverr);
endmodule // pwm_phase_dt_monitor
bind pwm_phase_dt pwm_phase_dt_monitor #(.PHASE_W(PHASE_W)) u_mon (.*);

// ### dv/tb_top.sv
// Bench of the phase and dead-time block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic low_uses_secondary;
  logic [11:0] paddr = 0, a, ad[4] = '{12'h008, 12'h00C, 12'h010, 12'h020};
  logic [31:0] pwdata = 0, prdata, rd, m[4] = '{0, 0, 0, 0};
  logic [31:0] mk[4] = '{32'hFFFF, 32'h3FFF, 32'h3FFF, 32'h0};
  logic [15:0] high_count, low_count;
  logic [13:0] dead_time, alt_dead_time;
  int err_count = 0, comparisons = 0, seed = 40161;
  always #4 pclk = ~pclk;
  pwm_phase_dt DUT (.*);
  task automatic chk(string n, logic [31:0] x, s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d of %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(logic w, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    for (int n = 0; n < 9 && pready !== 1'b1; n++) @(posedge pclk);
    chk("ready", 1, pready);
    if (pready !== 1'b1) stop_test();
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 36; k++) begin
      a = ad[k % 4];
      apb(0, 0);
      chk("reg", m[k % 4] & mk[k % 4], rd);
      m[k % 4] = k < 8 ? '1 : $random(seed);
      apb(1, m[k % 4]);
    end
    a = 12'h000;
    for (int k = 8; k < 16; k++) begin
      apb(1, k);
      repeat (3) @(posedge pclk);
      chk("mode", k > 13, low_uses_secondary);
    end
    a = 12'h004;
    apb(1, 32'h1234);
    a = 12'h008;
    apb(1, 32'h0ABC);
    a = 12'h000;
    apb(1, 32'h6);
    repeat (3) @(posedge pclk);
    chk("high_pre", 32'h1234, high_count);
    chk("low_pre", 32'h0ABC, low_count);
    apb(1, 32'h0);
    repeat (3) @(posedge pclk);
    chk("low_copy", 32'h1234, low_count);
    a = 12'h008;
    apb(1, 32'h5);
    a = 12'h000;
    apb(1, 32'h7);
    apb(1, 32'hF);
    rd = 0;
    repeat (20) begin
      @(posedge pclk);
      if (low_count > rd) rd = low_count;
    end
    chk("low_period", 32'h5, rd);
    stop_test();
  end
endmodule // tb_top
